/* src/mailbox_pkg.sv */
package mailbox_pkg;

   // register bus geometry: address is {bank, byte}
   localparam int          ADDR_W          = 9;
   localparam int          DATA_W          = 8;
   localparam int          ID_W            = 16;
   localparam int          MAX_INST        = 2;

   // lower page, visible from either bank
   localparam logic [7:0]  OFS_FLAG        = 8'h08;
   localparam logic [7:0]  OFS_MASK        = 8'h1F;
   localparam logic [7:0]  OFS_STAT1       = 8'h25;
   localparam logic [7:0]  OFS_STAT2       = 8'h26;
   localparam logic [7:0]  OFS_CAP         = 8'hA3;
   // message page, one copy per bank
   localparam logic [7:0]  OFS_ID_HI       = 8'h80;
   localparam logic [7:0]  OFS_TRIG        = 8'h81;
   localparam logic [7:0]  OFS_CHK         = 8'h85;
   localparam logic [7:0]  OFS_REPLY       = 8'h88;

   // field positions
   localparam int          FLAG_POS0       = 6;
   localparam int          STAT_BUSY_POS   = 7;
   localparam int          CAP_MODE_POS    = 5;
   localparam int          CAP_STOP_POS    = 0;

   // capability mode codes in bits 7..5
   localparam logic [2:0]  CAP_FG_ONE      = 3'h0;
   localparam logic [2:0]  CAP_FG_TWO      = 3'h2;
   localparam logic [2:0]  CAP_BG_ONE      = 3'h3;
   localparam logic [2:0]  CAP_BG_TWO      = 3'h5;

   // reset values
   localparam logic [7:0]  MASK_RST        = 8'h00;
   localparam logic [7:0]  STAT_RST        = 8'h00;
   localparam logic [1:0]  FLAG_RST        = 2'h0;

   // status codes: bit 7 busy, bit 6 failed
   localparam logic [7:0]  STAT_IN_PROG    = 8'h81;
   localparam logic [7:0]  STAT_SUCCESS    = 8'h01;
   localparam logic [7:0]  STAT_FAIL_EXEC  = 8'h42;
   localparam logic [7:0]  STAT_FAIL_ID    = 8'h43;
   localparam logic [7:0]  STAT_FAIL_CHK   = 8'h44;
   localparam logic [7:0]  STAT_ABORTED    = 8'h45;

   localparam logic [15:0] ABORT_ID        = 16'h0004;

   // capture hold-off: link clock edges, bounded by a time in case the clock stops
   localparam logic [3:0]  CAPTURE_EDGES   = 4'h2;
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          CAPTURE_MAX_NS  = 1000;
   localparam int          CAPTURE_MAX_CYC = CAPTURE_MAX_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_CAPTURE = 3'b001,
      ST_EXEC    = 3'b010,
      ST_STATUS  = 3'b011,
      ST_FLAG    = 3'b100
   } inst_state_t;

   // advertised command set, the same for every instance
   function automatic logic cmd_supported(input logic [15:0] id);
      cmd_supported = (id <= 16'h0004) ||
                      (id == 16'h0040) || (id == 16'h0041) ||
                      ((id >= 16'h0100) && (id <= 16'h010A));
   endfunction : cmd_supported

endpackage : mailbox_pkg

/* src/module_command_mailbox_engine.sv */
`timescale 1ns/1ps
module module_command_mailbox_engine #(
   parameter int NUM_INST        = 2,
   parameter bit BACKGROUND      = 1'b1,
   parameter bit TRIGGER_ON_STOP = 1'b0
) (
   input  wire logic                                                  clk_sys,
   input  wire logic                                                  resetn,
   input  wire logic [mailbox_pkg::ADDR_W-1:0]                        regAddr,
   input  wire logic [mailbox_pkg::DATA_W-1:0]                        regWrData,
   input  wire logic                                                  regWrEn,
   input  wire logic                                                  regRdEn,
   output logic      [mailbox_pkg::DATA_W-1:0]                        regRdData,
   output logic                                                       accessRefused,
   input  wire logic                                                  linkClk,
   input  wire logic                                                  linkStop,
   output logic      [mailbox_pkg::MAX_INST-1:0]                      execStart,
   output logic      [mailbox_pkg::MAX_INST-1:0]                      execAbort,
   output logic      [mailbox_pkg::MAX_INST-1:0][mailbox_pkg::ID_W-1:0] execCmdId,
   input  wire logic [mailbox_pkg::MAX_INST-1:0]                      execDone,
   input  wire logic [mailbox_pkg::MAX_INST-1:0]                      execFail,
   input  wire logic [mailbox_pkg::MAX_INST-1:0][mailbox_pkg::DATA_W-1:0] execReply,
   output logic                                                       irqN
);
   import mailbox_pkg::*;

   localparam logic [2:0] CAP_MODE = BACKGROUND ? ((NUM_INST == 2) ? CAP_BG_TWO : CAP_BG_ONE)
                                                : ((NUM_INST == 2) ? CAP_FG_TWO : CAP_FG_ONE);

   // link clock sampling: stage 1 only feeds stage 2
   logic        lnkSync1_r;
   logic        lnkSync2_r;
   logic        lnkSync3_r;
   logic        linkEdge;

   // per-instance state
   inst_state_t state_r   [MAX_INST];
   inst_state_t state_nxt [MAX_INST];
   logic [7:0]  idHi_r    [MAX_INST];
   logic [7:0]  idHi_nxt  [MAX_INST];
   logic [7:0]  idLo_r    [MAX_INST];
   logic [7:0]  idLo_nxt  [MAX_INST];
   logic [7:0]  chk_r     [MAX_INST];
   logic [7:0]  chk_nxt   [MAX_INST];
   logic [7:0]  reply_r   [MAX_INST];
   logic [7:0]  reply_nxt [MAX_INST];
   logic [7:0]  status_r  [MAX_INST];
   logic [7:0]  status_nxt[MAX_INST];
   logic [7:0]  result_r  [MAX_INST];
   logic [7:0]  result_nxt[MAX_INST];
   logic [3:0]  edgeCnt_r [MAX_INST];
   logic [3:0]  edgeCnt_nxt[MAX_INST];
   logic [15:0] timer_r   [MAX_INST];
   logic [15:0] timer_nxt [MAX_INST];
   logic        arm_r     [MAX_INST];
   logic        arm_nxt   [MAX_INST];
   logic [MAX_INST-1:0][ID_W-1:0] execCmdId_nxt;
   logic [MAX_INST-1:0]           execStart_nxt;
   logic [MAX_INST-1:0]           execAbort_nxt;

   // shared registers
   logic [1:0]  flag_r;
   logic [1:0]  flag_nxt;
   logic [1:0]  mask_r;
   logic [1:0]  mask_nxt;
   logic [7:0]  rdData_nxt;
   logic        irqN_nxt;

   // decode helpers
   logic        refuse;
   logic        wrOk;
   logic        rdOk;
   logic [7:0]  byteAddr;
   logic        bankSel;
   logic        anyBusy;
   logic        anyCapture;
   logic        trigWrite;
   logic        fire;
   logic [15:0] cmdNow;
   logic [7:0]  chkCalc;

   assign byteAddr = regAddr[7:0];
   assign bankSel  = regAddr[8];

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         lnkSync1_r <= 1'b0;
         lnkSync2_r <= 1'b0;
         lnkSync3_r <= 1'b0;
      end else begin
         lnkSync1_r <= linkClk;
         lnkSync2_r <= lnkSync1_r;
         lnkSync3_r <= lnkSync2_r;
      end
   end

   assign linkEdge = lnkSync2_r & ~lnkSync3_r;

   // refusal: foreground holds off for the whole command, background only while capturing
   always_comb begin
      anyBusy    = 1'b0;
      anyCapture = 1'b0;
      for (int i = 0; i < MAX_INST; i++) begin
         if (state_r[i] != ST_IDLE) begin
            anyBusy = 1'b1;
         end
         if (state_r[i] == ST_CAPTURE) begin
            anyCapture = 1'b1;
         end
      end
      refuse = BACKGROUND ? anyCapture : anyBusy;
      wrOk   = regWrEn && !refuse;
      rdOk   = regRdEn && !refuse;
   end

   assign accessRefused = refuse & (regWrEn | regRdEn);

   // instance engines
   always_comb begin
      trigWrite     = 1'b0;
      fire          = 1'b0;
      cmdNow        = '0;
      chkCalc       = '0;
      flag_nxt      = flag_r;
      mask_nxt      = mask_r;
      execStart_nxt = '0;
      execAbort_nxt = '0;
      execCmdId_nxt = execCmdId;

      // reading the flag byte clears it; a completion in the same cycle still lands
      if (rdOk && (byteAddr == OFS_FLAG)) begin
         flag_nxt = '0;
      end
      if (wrOk && (byteAddr == OFS_MASK)) begin
         mask_nxt = regWrData[FLAG_POS0 +: 2];
      end

      for (int i = 0; i < MAX_INST; i++) begin
         state_nxt[i]   = state_r[i];
         idHi_nxt[i]    = idHi_r[i];
         idLo_nxt[i]    = idLo_r[i];
         chk_nxt[i]     = chk_r[i];
         reply_nxt[i]   = reply_r[i];
         status_nxt[i]  = status_r[i];
         result_nxt[i]  = result_r[i];
         edgeCnt_nxt[i] = edgeCnt_r[i];
         timer_nxt[i]   = timer_r[i];
         arm_nxt[i]     = arm_r[i];

         if (i < NUM_INST) begin
            if (wrOk && (bankSel == i[0]) && (byteAddr == OFS_ID_HI)) begin
               idHi_nxt[i] = regWrData;
            end
            if (wrOk && (bankSel == i[0]) && (byteAddr == OFS_CHK)) begin
               chk_nxt[i] = regWrData;
            end
            trigWrite = wrOk && (bankSel == i[0]) && (byteAddr == OFS_TRIG);
            if (trigWrite) begin
               idLo_nxt[i] = regWrData;
            end
            // stop mode: the trigger byte arms, the end of the write burst launches
            if (TRIGGER_ON_STOP) begin
               fire   = linkStop && arm_r[i];
               cmdNow = {idHi_r[i], idLo_r[i]};
               if (trigWrite) begin
                  arm_nxt[i] = 1'b1;
               end else if (linkStop) begin
                  arm_nxt[i] = 1'b0;
               end
            end else begin
               fire   = trigWrite;
               cmdNow = {idHi_r[i], regWrData};
            end
         end else begin
            fire   = 1'b0;
            cmdNow = '0;
         end

         chkCalc = ~(execCmdId[i][15:8] + execCmdId[i][7:0]);

         case (state_r[i])
            ST_IDLE: begin
               // outside stop mode, foreground never gets here with another command running: access is refused
               if (fire) begin
                  state_nxt[i]     = ST_CAPTURE;
                  execCmdId_nxt[i] = cmdNow;
                  status_nxt[i]    = STAT_IN_PROG;
                  edgeCnt_nxt[i]   = '0;
                  timer_nxt[i]     = '0;
               end
            end
            ST_CAPTURE: begin
               if (linkEdge) begin
                  edgeCnt_nxt[i] = edgeCnt_r[i] + 4'h1;
               end
               timer_nxt[i] = timer_r[i] + 16'h0001;
               if ((edgeCnt_r[i] >= CAPTURE_EDGES) || (timer_r[i] >= 16'(CAPTURE_MAX_CYC))) begin
                  if (chk_r[i] != chkCalc) begin
                     result_nxt[i] = STAT_FAIL_CHK;
                     state_nxt[i]  = ST_STATUS;
                  end else if (!cmd_supported(execCmdId[i])) begin
                     result_nxt[i] = STAT_FAIL_ID;
                     state_nxt[i]  = ST_STATUS;
                  end else begin
                     execStart_nxt[i] = 1'b1;
                     state_nxt[i]     = ST_EXEC;
                  end
               end
            end
            ST_EXEC: begin
               if (fire && (cmdNow == ABORT_ID)) begin
                  execAbort_nxt[i] = 1'b1;
                  result_nxt[i]    = STAT_ABORTED;
                  state_nxt[i]     = ST_STATUS;
               end else if (execDone[i]) begin
                  result_nxt[i] = execFail[i] ? STAT_FAIL_EXEC : STAT_SUCCESS;
                  reply_nxt[i]  = execReply[i];
                  state_nxt[i]  = ST_STATUS;
               end
               // any other command while busy is dropped on the floor
            end
            ST_STATUS: begin
               status_nxt[i] = result_r[i];
               state_nxt[i]  = ST_FLAG;
            end
            ST_FLAG: begin
               flag_nxt[i]  = 1'b1;
               state_nxt[i] = ST_IDLE;
            end
            default: begin
               state_nxt[i] = ST_IDLE;
            end
         endcase
      end
   end

   // interrupt is registered so irqN falls the cycle after the flag
   always_comb begin
      irqN_nxt = ~|(flag_r & ~mask_r);
   end

   // read data, valid only in the cycle after the strobe
   always_comb begin
      rdData_nxt = '0;
      if (rdOk) begin
         case (byteAddr)
            OFS_FLAG:  rdData_nxt = {flag_r, 6'h00};
            OFS_MASK:  rdData_nxt = {mask_r, 6'h00};
            OFS_STAT1: rdData_nxt = status_r[0];
            OFS_STAT2: rdData_nxt = (NUM_INST == 2) ? status_r[1] : 8'h00;
            OFS_CAP:   rdData_nxt = {CAP_MODE, 4'h0, TRIGGER_ON_STOP};
            OFS_ID_HI: rdData_nxt = (int'(bankSel) < NUM_INST) ? idHi_r[bankSel] : 8'h00;
            OFS_TRIG:  rdData_nxt = (int'(bankSel) < NUM_INST) ? idLo_r[bankSel] : 8'h00;
            OFS_CHK:   rdData_nxt = (int'(bankSel) < NUM_INST) ? chk_r[bankSel] : 8'h00;
            OFS_REPLY: rdData_nxt = (int'(bankSel) < NUM_INST) ? reply_r[bankSel] : 8'h00;
            default:   rdData_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         for (int i = 0; i < MAX_INST; i++) begin
            state_r[i]   <= ST_IDLE;
            idHi_r[i]    <= 8'h00;
            idLo_r[i]    <= 8'h00;
            chk_r[i]     <= 8'h00;
            reply_r[i]   <= 8'h00;
            status_r[i]  <= STAT_RST;
            result_r[i]  <= STAT_RST;
            edgeCnt_r[i] <= 4'h0;
            timer_r[i]   <= 16'h0000;
            arm_r[i]     <= 1'b0;
         end
         execCmdId <= '0;
         execStart <= '0;
         execAbort <= '0;
         flag_r    <= FLAG_RST;
         mask_r    <= MASK_RST[FLAG_POS0 +: 2];
         regRdData <= 8'h00;
         irqN      <= 1'b1;
      end else begin
         for (int i = 0; i < MAX_INST; i++) begin
            state_r[i]   <= state_nxt[i];
            idHi_r[i]    <= idHi_nxt[i];
            idLo_r[i]    <= idLo_nxt[i];
            chk_r[i]     <= chk_nxt[i];
            reply_r[i]   <= reply_nxt[i];
            status_r[i]  <= status_nxt[i];
            result_r[i]  <= result_nxt[i];
            edgeCnt_r[i] <= edgeCnt_nxt[i];
            timer_r[i]   <= timer_nxt[i];
            arm_r[i]     <= arm_nxt[i];
         end
         execCmdId <= execCmdId_nxt;
         execStart <= execStart_nxt;
         execAbort <= execAbort_nxt;
         flag_r    <= flag_nxt;
         mask_r    <= mask_nxt;
         regRdData <= rdData_nxt;
         irqN      <= irqN_nxt;
      end
   end

endmodule : module_command_mailbox_engine

/* tb/mailbox_sva.sv */
`timescale 1ns/1ps
module mailbox_sva (
   input wire logic             clk_sys,
   input wire logic             resetn,
   input wire logic             regWrEn,
   input wire logic             regRdEn,
   input wire logic [7:0]       regRdData,
   input wire logic             accessRefused,
   input wire logic [1:0]       execStart,
   input wire logic [1:0]       execAbort,
   input wire logic [1:0][15:0] execCmdId,
   input wire logic             irqN
);
   import mailbox_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // own copy of the advertised set, so a wrong design table cannot hide itself
   function automatic logic known(input logic [15:0] id);
      return id <= 16'h0004 || id == 16'h0040 || id == 16'h0041 || (id >= 16'h0100 && id <= 16'h010A);
   endfunction : known
   refuse_strobe_a: assert property (accessRefused |-> (regRdEn || regWrEn))
      else $error("refusal without a strobe");
   refused_rd_zero_a: assert property (regRdEn && accessRefused |=> regRdData == 8'h00)
      else $error("refused read returned data");
   start_id_one_a: assert property (execStart[0] |-> known(execCmdId[0]))
      else $error("instance one started an unknown id");
   start_id_two_a: assert property (execStart[1] |-> known(execCmdId[1]))
      else $error("instance two started an unknown id");
   id_stands_a: assert property (execStart[0] |=> $stable(execCmdId[0]) [*4])
      else $error("command id moved during execution");
   abort_no_start_a: assert property (execAbort[0] |-> !execStart[0] ##1 !execStart[0])
      else $error("abort started a command");
   start_once_a: assert property (execStart[0] |=> !execStart[0] [*8])
      else $error("second start while busy");
   irq_rise_cause_a: assert property ($rose(irqN) |-> $past(regRdEn) || $past(regRdEn, 2) ||
                                      $past(regWrEn) || $past(regWrEn, 2))
      else $error("interrupt released without host access");
   reset_idle_a: assert property ($rose(resetn) |-> irqN && execStart == 2'h0 && regRdData == 8'h00)
      else $error("outputs not idle after reset");
   cover property (execStart[0] ##[1:200] execStart[1]);
   cover property (regRdEn && accessRefused);
   cover property (execAbort[0]);
   cover property ($fell(irqN));
endmodule : mailbox_sva

/* tb/exec_backend_model.sv */
`timescale 1ns/1ps
module exec_backend_model #(
   parameter int DLY = 20
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic [1:0]       execStart,
   input  wire logic [1:0]       execAbort,
   input  wire logic [1:0][15:0] execCmdId,
   input  wire logic [1:0]       stall,
   input  wire logic [1:0]       failReq,
   output logic      [1:0]       execDone,
   output logic      [1:0]       execFail,
   output logic      [1:0][7:0]  execReply
);
   import mailbox_pkg::*;
   int cnt [MAX_INST];
   always @(posedge clk_sys) begin
      for (int i = 0; i < MAX_INST; i++) begin
         execDone[i] <= 1'b0;
         if (!resetn || execAbort[i]) begin
            cnt[i] <= 0;
         end else if (execStart[i]) begin
            cnt[i] <= DLY;
         end else if (cnt[i] > 0 && !stall[i]) begin
            cnt[i] <= cnt[i] - 1;
            execDone[i] <= (cnt[i] == 1);
         end
      end
   end
   // outside the done pulse the result lines show the inverse, so a late sample is caught
   always_comb begin
      for (int i = 0; i < MAX_INST; i++) begin
         execFail[i] = execDone[i] ? failReq[i] : ~failReq[i];
         execReply[i] = execCmdId[i][7:0] ^ (execDone[i] ? 8'h5A : 8'hA5);
      end
   end
endmodule : exec_backend_model

/* tb/tb_module_command_mailbox_engine.sv */
`timescale 1ns/1ps
module tb_module_command_mailbox_engine;
   import mailbox_pkg::*;
   typedef struct packed {
      logic        bank;
      logic [15:0] id;
      logic        fail;
      logic        bad;
      logic [7:0]  stat;
   } row_t;
   logic             clk_sys, resetn, regWrEn, regRdEn, linkClk, linkRun, accessRefused, irqN;
   logic [8:0]       regAddr;
   logic [7:0]       regWrData, regRdData;
   logic [1:0]       execStart, execAbort, execDone, execFail, stall, failReq;
   logic [1:0][15:0] execCmdId;
   logic [1:0][7:0]  execReply;
   logic             linkStop = 1'b0;
   int               fails = 0;
   int               checked = 0;
   row_t             rows [6] = '{'{1'b0, 16'h0001, 1'b0, 1'b0, STAT_SUCCESS},
                                  '{1'b1, 16'h0040, 1'b0, 1'b0, STAT_SUCCESS},
                                  '{1'b0, 16'h0100, 1'b1, 1'b0, STAT_FAIL_EXEC},
                                  '{1'b1, 16'h0005, 1'b0, 1'b0, STAT_FAIL_ID},
                                  '{1'b0, 16'h0041, 1'b0, 1'b1, STAT_FAIL_CHK},
                                  '{1'b1, 16'h010A, 1'b0, 1'b0, STAT_SUCCESS}};
   module_command_mailbox_engine #(.NUM_INST(2), .BACKGROUND(1'b1), .TRIGGER_ON_STOP(1'b0))
   module_command_mailbox_engine_inst (.clk_sys, .resetn, .regAddr, .regWrData, .regWrEn, .regRdEn,
      .regRdData, .accessRefused, .linkClk, .linkStop, .execStart, .execAbort, .execCmdId, .execDone,
      .execFail, .execReply, .irqN);
   exec_backend_model #(.DLY(20)) exec_backend_model_inst (.clk_sys, .resetn, .execStart, .execAbort,
      .execCmdId, .stall, .failReq, .execDone, .execFail, .execReply);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // link clock runs only while a command is being handed over
   always #62.5 if (linkRun) linkClk = ~linkClk;
   task automatic complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask : cmp1
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic refd);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      #1 refd = accessRefused;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   task automatic rdChk(input logic [8:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       r;
      rd(a, d, r);
      cmp1(r, 1'b0);
      cmp8(d, exp);
   endtask : rdChk
   function automatic logic [8:0] statA(input logic b);
      return {1'b0, b ? OFS_STAT2 : OFS_STAT1};
   endfunction : statA
   task automatic sendCmd(input logic b, input logic [15:0] id, input logic bad, input logic probe);
      logic [7:0] d;
      logic       r;
      linkRun = 1'b1;
      wr({b, OFS_ID_HI}, id[15:8]);
      wr({b, OFS_CHK}, ~(id[15:8] + id[7:0]) ^ {7'h00, bad});
      wr({b, OFS_TRIG}, id[7:0]);
      if (probe) begin
         rd({b, OFS_MASK}, d, r);
         cmp1(r, 1'b1);
         cmp8(d, 8'h00);
         for (int k = 0; k < 300 && r; k++) rd({b, OFS_MASK}, d, r);
         cmp1(r, 1'b0);
         if (r) complete_run();
      end
      linkRun = 1'b0;
   endtask : sendCmd
   task automatic waitDone(input logic b);
      logic [7:0] d;
      logic       r;
      d = 8'h80;
      for (int k = 0; k < 500 && d[7]; k++) rd(statA(b), d, r);
      cmp1(d[7], 1'b0);
      if (d[7]) complete_run();
      repeat (3) @(posedge clk_sys);
      // step off the edge so registered outputs have settled
      #1;
   endtask : waitDone
   initial begin
      repeat (100000) @(posedge clk_sys);
      cmp1(1'b1, 1'b0);
      complete_run();
   end
   initial begin
      {resetn, regWrEn, regRdEn, linkClk, linkRun} = '0;
      {regAddr, regWrData, stall, failReq} = '0;
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      rdChk({1'b0, OFS_FLAG}, {FLAG_RST, 6'h00});
      rdChk({1'b0, OFS_MASK}, MASK_RST);
      rdChk(statA(1'b0), STAT_RST);
      rdChk(statA(1'b1), STAT_RST);
      rdChk({1'b0, OFS_CAP}, {CAP_BG_TWO, 5'h00});
      wr({1'b0, 8'h50}, 8'hFF);
      rdChk({1'b0, 8'h50}, 8'h00);
      cmp1(irqN, 1'b1);
      $display("test reset done");
      foreach (rows[i]) begin
         failReq[rows[i].bank] <= rows[i].fail;
         sendCmd(rows[i].bank, rows[i].id, rows[i].bad, 1'b1);
         waitDone(rows[i].bank);
         rdChk(statA(rows[i].bank), rows[i].stat);
         cmp1(irqN, 1'b0);
         rdChk({1'b0, OFS_FLAG}, rows[i].bank ? 8'h80 : 8'h40);
         if (rows[i].stat == STAT_SUCCESS) begin
            rdChk({rows[i].bank, OFS_REPLY}, rows[i].id[7:0] ^ 8'h5A);
         end
      end
      $display("test table done");
      stall <= 2'b11;
      sendCmd(1'b0, 16'h0101, 1'b0, 1'b1);
      sendCmd(1'b1, 16'h0102, 1'b0, 1'b1);
      rdChk(statA(1'b0), STAT_IN_PROG);
      rdChk(statA(1'b1), STAT_IN_PROG);
      // deliberate command to a busy instance
      sendCmd(1'b0, 16'h0002, 1'b0, 1'b0);
      rdChk(statA(1'b0), STAT_IN_PROG);
      stall <= 2'b01;
      waitDone(1'b1);
      rdChk(statA(1'b1), STAT_SUCCESS);
      rdChk({1'b0, OFS_FLAG}, 8'h80);
      rdChk(statA(1'b0), STAT_IN_PROG);
      sendCmd(1'b0, ABORT_ID, 1'b0, 1'b0);
      waitDone(1'b0);
      rdChk(statA(1'b0), STAT_ABORTED);
      rdChk({1'b0, OFS_FLAG}, 8'h40);
      stall <= 2'b00;
      $display("test concurrent done");
      wr({1'b0, OFS_MASK}, 8'h40);
      rdChk({1'b0, OFS_MASK}, 8'h40);
      sendCmd(1'b0, 16'h0003, 1'b0, 1'b1);
      waitDone(1'b0);
      cmp1(irqN, 1'b1);
      wr({1'b0, OFS_MASK}, 8'h00);
      repeat (3) @(posedge clk_sys);
      #1;
      cmp1(irqN, 1'b0);
      $display("test mask done");
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rdChk(statA(1'b0), STAT_RST);
      rdChk({1'b0, OFS_FLAG}, 8'h00);
      cmp1(irqN, 1'b1);
      $display("test rereset done");
      complete_run();
   end
endmodule : tb_module_command_mailbox_engine
bind module_command_mailbox_engine mailbox_sva mailbox_sva_inst (.clk_sys(clk_sys), .resetn(resetn),
   .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .accessRefused(accessRefused),
   .execStart(execStart), .execAbort(execAbort), .execCmdId(execCmdId), .irqN(irqN));
